// [rtl/dppu_parity_unit.sv]
// Byte-lane parity check and generation for both 36-bit ports.
// Assumes both port buses are synchronous to ref_clk_in; strap-like
// selects arrive from pins and are synchronised here.
// What this block does
// [RULE1] Check parity on both ports, odd/even selectable
// [RULE2] Four parity trees per port
// [RULE3] Port A lanes 0-8..27-35, top bit parity
// [RULE4] Per-lane error signal low on bad parity
// [RULE5] Port A flag low if any lane bad
// [RULE6] Port B lanes split the same way
// [RULE7] Port B flag low if any lane bad
// [RULE8] Reduced port B size masks invalid lanes
// [RULE9] Checking never alters or blocks transfers
// [RULE10] Per-port select enables generation on reads
// [RULE11] Odd/even select also sets generated type
// [RULE12] Writes store all 36 bits unchanged
// [RULE13] FIFO-read parity from lower eight bits
// [RULE14] Substitute generated bit, else stored bit
// [RULE15] Mailbox generation uses the checking trees
// [RULE16] Mailbox read with generation holds flag high
// [RULE17] Mailbox contents never modified by generation
// [RULE18] Port B supports byte, word, long sizes
// [RULE19] Both size selects high means mailbox access
// [RULE20] Flags and generated parity registered on clock
// [RULE21] Flags high after reset until evaluated
`timescale 1ns/100ps
module dppu_parity_unit
(
  input wire logic ref_clk_in, // Reference clock, 25 MHz
  input wire logic srst_in, // Synchronous reset, active high
  input wire logic parity_odd_select_in, // Pin: high odd, low even
  input wire logic porta_parity_gen_select_in, // Pin: port A generate
  input wire logic portb_parity_gen_select_in, // Pin: port B generate
  input wire logic porta_wr_in, // Port A write cycle
  input wire logic porta_rd_in, // Port A read cycle
  input wire logic porta_mbx_select_in, // Port A access targets mailbox
  input wire logic [dppu_pkg::DPPU_WORD_W-1:0] porta_data_in, // Port A bus in
  input wire logic [dppu_pkg::DPPU_WORD_W-1:0] porta_fifo_word_in, // FIFO word
  input wire logic [dppu_pkg::DPPU_WORD_W-1:0] porta_mbx_word_in, // Mailbox
  input wire logic portb_wr_in, // Port B write cycle
  input wire logic portb_rd_in, // Port B read cycle
  input wire logic portb_size_select_lo_in, // Port B size select low
  input wire logic portb_size_select_hi_in, // Port B size select high
  input wire logic [dppu_pkg::DPPU_WORD_W-1:0] portb_data_in, // Port B bus in
  input wire logic [dppu_pkg::DPPU_WORD_W-1:0] portb_fifo_word_in, // FIFO word
  input wire logic [dppu_pkg::DPPU_WORD_W-1:0] portb_mbx_word_in, // Mailbox
  input wire logic [dppu_pkg::DPPU_ADDR_W-1:0] reg_addr_in, // Register address
  input wire logic [dppu_pkg::DPPU_DATA_W-1:0] reg_wdata_in, // Write data
  input wire logic reg_wr_in, // Register write strobe
  input wire logic reg_rd_in, // Register read strobe
  output logic [dppu_pkg::DPPU_DATA_W-1:0] reg_rdata_out, // Read data
  output logic porta_parity_error_flag_n_out, // Port A error, low active
  output logic portb_parity_error_flag_n_out, // Port B error, low active
  output logic [dppu_pkg::DPPU_WORD_W-1:0] porta_rd_data_out, // Port A out
  output logic [dppu_pkg::DPPU_WORD_W-1:0] portb_rd_data_out, // Port B out
  output logic porta_store_out, // Port A word to store
  output logic portb_store_out, // Port B word to store
  output logic porta_store_mbx_out, // Port A store goes to mailbox
  output logic portb_store_mbx_out, // Port B store goes to mailbox
  output logic [dppu_pkg::DPPU_WORD_W-1:0] porta_store_data_out, // A store
  output logic [dppu_pkg::DPPU_WORD_W-1:0] portb_store_data_out, // B store
  output logic [1:0] portb_size_out // Port B size in force
);
  import dppu_pkg::*;

  // Pin synchronisers: odd, gen A, gen B.
  logic [2:0] pin_meta_q;
  logic [2:0] pin_sync_q;
  logic odd_sel;
  logic [DPPU_PORTS-1:0] gen_sel;

  logic [1:0] ctrl_q;
  logic [7:0] status_q;
  logic [7:0] status_d;
  logic [1:0] size_q;
  logic [DPPU_PORTS-1:0] flag_q;
  logic [DPPU_PORTS-1:0][DPPU_WORD_W-1:0] rd_data_q;
  logic [DPPU_PORTS-1:0][DPPU_WORD_W-1:0] store_data_q;
  logic [DPPU_PORTS-1:0] store_q;
  logic [DPPU_PORTS-1:0] store_mbx_q;
  logic [DPPU_DATA_W-1:0] rdata_q;

  logic [DPPU_PORTS-1:0] rd;
  logic [DPPU_PORTS-1:0] wr;
  logic [DPPU_PORTS-1:0] mbx;
  logic [DPPU_PORTS-1:0] chk_en;
  logic [DPPU_PORTS-1:0] evaluated;
  logic [DPPU_PORTS-1:0][DPPU_WORD_W-1:0] data_word;
  logic [DPPU_PORTS-1:0][DPPU_WORD_W-1:0] fifo_word;
  logic [DPPU_PORTS-1:0][DPPU_WORD_W-1:0] mbx_word;
  logic [DPPU_PORTS-1:0][DPPU_WORD_W-1:0] src_word;
  logic [DPPU_PORTS-1:0][DPPU_WORD_W-1:0] chk_word;
  logic [DPPU_PORTS-1:0][DPPU_WORD_W-1:0] out_word;
  logic [DPPU_PORTS-1:0][DPPU_LANES-1:0] chk_err_n;
  logic [DPPU_PORTS-1:0][DPPU_LANES-1:0] chk_gen;
  logic [DPPU_PORTS-1:0][DPPU_LANES-1:0] fifo_gen;
  logic [DPPU_PORTS-1:0][DPPU_LANES-1:0] lane_mask;
  logic [DPPU_PORTS-1:0][DPPU_LANES-1:0] lane_bad;
  logic [1:0] size_pins;

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      pin_meta_q <= 3'h0;
      pin_sync_q <= 3'h0;
    end
    else
    begin
      pin_meta_q <= {portb_parity_gen_select_in,
                     porta_parity_gen_select_in, parity_odd_select_in};
      pin_sync_q <= pin_meta_q;
    end
  end

  assign odd_sel = pin_sync_q[0]; // RULE1 RULE11
  assign gen_sel = pin_sync_q[2:1]; // RULE10

  // Both size selects high is a mailbox access, not a size change.
  assign size_pins = {portb_size_select_hi_in, portb_size_select_lo_in};
  assign mbx[DPPU_PA] = porta_mbx_select_in;
  assign mbx[DPPU_PB] = (size_pins == DPPU_SIZE_MBOX); // RULE19

  assign rd = {portb_rd_in, porta_rd_in};
  assign wr = {portb_wr_in, porta_wr_in};
  assign data_word = {portb_data_in, porta_data_in};
  assign fifo_word = {portb_fifo_word_in, porta_fifo_word_in};
  assign mbx_word = {portb_mbx_word_in, porta_mbx_word_in};
  assign chk_en = {ctrl_q[DPPU_CTRL_CHK_B], ctrl_q[DPPU_CTRL_CHK_A]};
  assign evaluated = rd | wr;

  // The size is held across a mailbox access so the FIFO transfer that
  // was in progress resumes with the same lane tracking.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      size_q <= DPPU_SIZE_RESET;
    else if (!mbx[DPPU_PB])
      size_q <= size_pins; // RULE18 RULE19
  end

  always_comb
  begin
    lane_mask[DPPU_PA] = DPPU_LANES_LONG;
    case (size_q)
      DPPU_SIZE_WORD: lane_mask[DPPU_PB] = DPPU_LANES_WORD;
      DPPU_SIZE_BYTE: lane_mask[DPPU_PB] = DPPU_LANES_BYTE;
      default: lane_mask[DPPU_PB] = DPPU_LANES_LONG;
    endcase
    // Mailbox words are always full width.
    if (mbx[DPPU_PB])
      lane_mask[DPPU_PB] = DPPU_LANES_LONG; // RULE8
  end

  // Reads look at the word leaving the port, writes at the one entering.
  always_comb
  begin
    for (int p = 0; p < DPPU_PORTS; p++)
    begin
      src_word[p] = mbx[p] ? mbx_word[p] : fifo_word[p];
      chk_word[p] = rd[p] ? src_word[p] : data_word[p];
    end
  end

  genvar gp, gl;
  generate
    for (gp = 0; gp < DPPU_PORTS; gp++)
    begin : g_port
      for (gl = 0; gl < DPPU_LANES; gl++)
      begin : g_lane
        // Checking tree, also the mailbox generator.
        dppu_lane_tree u_chk
        (
          .lane_in(chk_word[gp][gl*DPPU_LANE_W +: DPPU_LANE_W]), // RULE3 RULE6
          .odd_in(odd_sel),
          .gen_bit_out(chk_gen[gp][gl]),
          .err_n_out(chk_err_n[gp][gl]) // RULE2 RULE4
        );
        // FIFO read generator.
        dppu_lane_tree u_gen
        (
          .lane_in(fifo_word[gp][gl*DPPU_LANE_W +: DPPU_LANE_W]), // RULE13
          .odd_in(odd_sel),
          .gen_bit_out(fifo_gen[gp][gl]),
          .err_n_out()
        );
      end
    end
  endgenerate

  // Only the output copy carries substituted bits; the stored word is
  // never written back.
  always_comb
  begin
    for (int p = 0; p < DPPU_PORTS; p++)
    begin
      out_word[p] = src_word[p];
      lane_bad[p] = ~chk_err_n[p] & lane_mask[p];
      for (int l = 0; l < DPPU_LANES; l++)
      begin
        if (gen_sel[p])
          out_word[p][l*DPPU_LANE_W + DPPU_LANE_W - 1] =
            mbx[p] ? chk_gen[p][l] : fifo_gen[p][l]; // RULE14 RULE15 RULE17
      end
    end
  end

  // Flags update only on edges that carry a word.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      flag_q <= DPPU_FLAG_RESET; // RULE21
    else
    begin
      for (int p = 0; p < DPPU_PORTS; p++)
      begin
        if (rd[p] && mbx[p] && gen_sel[p])
          flag_q[p] <= 1'b1; // RULE16
        else if (evaluated[p])
          flag_q[p] <= !(chk_en[p] && (|lane_bad[p])); // RULE5 RULE7 RULE8 RULE20
      end
    end
  end

  // Data paths never depend on the check result.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
    begin
      rd_data_q <= '0;
      store_data_q <= '0;
      store_q <= 2'h0;
      store_mbx_q <= 2'h0;
    end
    else
    begin
      store_q <= wr; // RULE9
      store_mbx_q <= wr & mbx;
      for (int p = 0; p < DPPU_PORTS; p++)
      begin
        if (rd[p])
          rd_data_q[p] <= out_word[p]; // RULE20
        if (wr[p])
          store_data_q[p] <= data_word[p]; // RULE12
      end
    end
  end

  // Sticky lane errors; a new error in the clearing cycle stays set.
  always_comb
  begin
    status_d = status_q;
    if (reg_wr_in && reg_addr_in == DPPU_REG_STATUS)
      status_d = status_q & ~reg_wdata_in[7:0];
    if (evaluated[DPPU_PA] && chk_en[DPPU_PA])
      status_d[DPPU_STAT_A_LSB +: DPPU_LANES] =
        status_d[DPPU_STAT_A_LSB +: DPPU_LANES] | lane_bad[DPPU_PA];
    if (evaluated[DPPU_PB] && chk_en[DPPU_PB])
      status_d[DPPU_STAT_B_LSB +: DPPU_LANES] =
        status_d[DPPU_STAT_B_LSB +: DPPU_LANES] | lane_bad[DPPU_PB];
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      status_q <= DPPU_STATUS_RESET;
    else
      status_q <= status_d;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      ctrl_q <= DPPU_CTRL_RESET;
    else if (reg_wr_in && reg_addr_in == DPPU_REG_CTRL)
      ctrl_q <= reg_wdata_in[1:0];
  end

  // Unmapped addresses read as zero; data stands only the next cycle.
  always_ff @(posedge ref_clk_in)
  begin
    if (srst_in)
      rdata_q <= '0;
    else if (reg_rd_in)
    begin
      case (reg_addr_in)
        DPPU_REG_CTRL: rdata_q <= {30'h0, ctrl_q};
        DPPU_REG_STATUS: rdata_q <= {24'h0, status_q};
        DPPU_REG_FLAGS: rdata_q <= {25'h0, size_q, gen_sel, odd_sel, flag_q};
        default: rdata_q <= '0;
      endcase
    end
    else
      rdata_q <= '0;
  end

  assign reg_rdata_out = rdata_q;
  assign porta_parity_error_flag_n_out = flag_q[DPPU_PA];
  assign portb_parity_error_flag_n_out = flag_q[DPPU_PB];
  assign porta_rd_data_out = rd_data_q[DPPU_PA];
  assign portb_rd_data_out = rd_data_q[DPPU_PB];
  assign porta_store_out = store_q[DPPU_PA];
  assign portb_store_out = store_q[DPPU_PB];
  assign porta_store_mbx_out = store_mbx_q[DPPU_PA];
  assign portb_store_mbx_out = store_mbx_q[DPPU_PB];
  assign porta_store_data_out = store_data_q[DPPU_PA];
  assign portb_store_data_out = store_data_q[DPPU_PB];
  assign portb_size_out = size_q;

  property p_flag_after_reset;
    @(posedge ref_clk_in) disable iff (srst_in)
    $past(srst_in) |-> flag_q == DPPU_FLAG_RESET;
  endproperty
  a_flag_after_reset: assert property (p_flag_after_reset) // RULE21
    else $error("Flags not high after reset.");

  property p_a_error;
    @(posedge ref_clk_in) disable iff (srst_in)
    (wr[DPPU_PA] && ctrl_q[DPPU_CTRL_CHK_A] && !(&chk_err_n[DPPU_PA]))
      |=> !porta_parity_error_flag_n_out;
  endproperty
  a_a_error: assert property (p_a_error) // RULE5
    else $error("Port A lane error did not lower the flag.");

  property p_b_error;
    @(posedge ref_clk_in) disable iff (srst_in)
    (wr[DPPU_PB] && !mbx[DPPU_PB] && size_q == DPPU_SIZE_LONG &&
     ctrl_q[DPPU_CTRL_CHK_B] && !(&chk_err_n[DPPU_PB]))
      |=> !portb_parity_error_flag_n_out;
  endproperty
  a_b_error: assert property (p_b_error) // RULE7
    else $error("Port B lane error did not lower the flag.");

  property p_b_mask;
    @(posedge ref_clk_in) disable iff (srst_in)
    (wr[DPPU_PB] && !mbx[DPPU_PB] && size_q == DPPU_SIZE_BYTE &&
     chk_err_n[DPPU_PB][0]) |=> portb_parity_error_flag_n_out;
  endproperty
  a_b_mask: assert property (p_b_mask) // RULE8
    else $error("Invalid port B lane raised an error.");

  property p_mbx_hold;
    @(posedge ref_clk_in) disable iff (srst_in)
    (rd[DPPU_PB] && mbx[DPPU_PB] && gen_sel[DPPU_PB])
      |=> portb_parity_error_flag_n_out;
  endproperty
  a_mbx_hold: assert property (p_mbx_hold) // RULE16
    else $error("Port B flag not held high on mailbox read.");

  property p_store_raw;
    @(posedge ref_clk_in) disable iff (srst_in)
    porta_wr_in |=> porta_store_out &&
      porta_store_data_out == $past(porta_data_in);
  endproperty
  a_store_raw: assert property (p_store_raw) // RULE12
    else $error("Port A stored word was altered.");

  property p_fifo_gen;
    @(posedge ref_clk_in) disable iff (srst_in)
    (porta_rd_in && !porta_mbx_select_in && gen_sel[DPPU_PA] &&
     $stable(odd_sel)) |=> (^porta_rd_data_out[8:0]) == $past(odd_sel);
  endproperty
  a_fifo_gen: assert property (p_fifo_gen) // RULE13
    else $error("Port A generated parity wrong on lane 0.");

  property p_mbx_gen;
    @(posedge ref_clk_in) disable iff (srst_in)
    (rd[DPPU_PB] && mbx[DPPU_PB] && gen_sel[DPPU_PB] && $stable(odd_sel))
      |=> (^portb_rd_data_out[35:27]) == $past(odd_sel) &&
          portb_rd_data_out[34:27] == $past(portb_mbx_word_in[34:27]);
  endproperty
  a_mbx_gen: assert property (p_mbx_gen) // RULE15
    else $error("Port B mailbox parity wrong on lane 3.");

  property p_no_gen;
    @(posedge ref_clk_in) disable iff (srst_in)
    (portb_rd_in && !gen_sel[DPPU_PB]) |=>
      portb_rd_data_out == $past(src_word[DPPU_PB]);
  endproperty
  a_no_gen: assert property (p_no_gen) // RULE14
    else $error("Port B read word changed without generation.");

  property p_size_hold;
    @(posedge ref_clk_in) disable iff (srst_in)
    mbx[DPPU_PB] |=> $stable(size_q);
  endproperty
  a_size_hold: assert property (p_size_hold) // RULE19
    else $error("Mailbox access changed the port B size.");

  property p_flag_idle;
    @(posedge ref_clk_in) disable iff (srst_in)
    !(rd[DPPU_PA] || wr[DPPU_PA]) |=> $stable(porta_parity_error_flag_n_out);
  endproperty
  a_flag_idle: assert property (p_flag_idle) // RULE20
    else $error("Port A flag moved without a word.");
endmodule // dppu_parity_unit

// [rtl/dppu_pkg.sv]
// Constants shared by the dual-port byte parity unit and its lane tree.
// Assumes both bus ports are sampled on the one reference clock.
package dppu_pkg;
  localparam int DPPU_WORD_W = 36;
  localparam int DPPU_LANES = 4;
  localparam int DPPU_LANE_W = 9;
  localparam int DPPU_PORTS = 2;
  localparam int DPPU_ADDR_W = 4;
  localparam int DPPU_DATA_W = 32;
  // Index of each port inside the internal per-port arrays.
  localparam int DPPU_PA = 0;
  localparam int DPPU_PB = 1;
  // Port B size code as {size_select_hi, size_select_lo}.
  localparam logic [1:0] DPPU_SIZE_LONG = 2'h0;
  localparam logic [1:0] DPPU_SIZE_WORD = 2'h1;
  localparam logic [1:0] DPPU_SIZE_BYTE = 2'h2;
  localparam logic [1:0] DPPU_SIZE_MBOX = 2'h3;
  // Byte lanes that carry valid data for each size.
  localparam logic [3:0] DPPU_LANES_LONG = 4'hF;
  localparam logic [3:0] DPPU_LANES_WORD = 4'h3;
  localparam logic [3:0] DPPU_LANES_BYTE = 4'h1;
  // Register offsets on the software port.
  localparam logic [3:0] DPPU_REG_CTRL = 4'h0;
  localparam logic [3:0] DPPU_REG_STATUS = 4'h4;
  localparam logic [3:0] DPPU_REG_FLAGS = 4'h8;
  // Field positions.
  localparam int DPPU_CTRL_CHK_A = 0;
  localparam int DPPU_CTRL_CHK_B = 1;
  localparam int DPPU_STAT_A_LSB = 0;
  localparam int DPPU_STAT_B_LSB = 4;
  // Reset values.
  localparam logic [1:0] DPPU_CTRL_RESET = 2'h3;
  localparam logic [7:0] DPPU_STATUS_RESET = 8'h00;
  localparam logic [1:0] DPPU_FLAG_RESET = 2'h3;
  localparam logic [1:0] DPPU_SIZE_RESET = 2'h0;
endpackage

// [rtl/dppu_lane_tree.sv]
// One parity tree for a 9-bit byte lane: checks the lane and generates
// the parity bit from its lower eight bits.
// Assumes the polarity select is already synchronised.
`timescale 1ns/100ps
module dppu_lane_tree
(
  input wire logic [dppu_pkg::DPPU_LANE_W-1:0] lane_in, // Lane, parity on top
  input wire logic odd_in, // High selects odd parity
  output logic gen_bit_out, // Parity bit made from lower eight bits
  output logic err_n_out // Low when lane parity is wrong
);
  import dppu_pkg::*;

  always_comb
  begin
    gen_bit_out = (^lane_in[DPPU_LANE_W-2:0]) ^ odd_in;
    err_n_out = ((^lane_in) == odd_in);
  end
endmodule // dppu_lane_tree

// [sim/dppu_store_model.sv]
// Far-side storage for both ports: keeps what one port wrote and offers it to the other port's reads.
// Assumes the unit's registered store pulses and a single reference clock.
`timescale 1ns/100ps
module dppu_store_model
(
  input wire logic clk_in, // Reference clock
  input wire logic srst_in, // Synchronous reset, active high
  input wire logic a_store_in, // Port A wrote a word
  input wire logic a_mbx_in, // Port A word goes to mailbox
  input wire logic [dppu_pkg::DPPU_WORD_W-1:0] a_data_in, // Port A stored word
  input wire logic b_store_in, // Port B wrote a word
  input wire logic b_mbx_in, // Port B word goes to mailbox
  input wire logic [dppu_pkg::DPPU_WORD_W-1:0] b_data_in, // Port B stored word
  output logic [dppu_pkg::DPPU_WORD_W-1:0] a_fifo_out, // Word port A reads from FIFO
  output logic [dppu_pkg::DPPU_WORD_W-1:0] a_mbx_out, // Mailbox port A reads
  output logic [dppu_pkg::DPPU_WORD_W-1:0] b_fifo_out, // Word port B reads from FIFO
  output logic [dppu_pkg::DPPU_WORD_W-1:0] b_mbx_out // Mailbox port B reads
);
  import dppu_pkg::*;
  // Stores keep the whole word; reads never write back, so generated parity cannot reach storage.
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      a_fifo_out <= '0;
      a_mbx_out <= '0;
      b_fifo_out <= '0;
      b_mbx_out <= '0;
    end
    else
    begin
      if (a_store_in && a_mbx_in) b_mbx_out <= a_data_in;
      if (a_store_in && !a_mbx_in) b_fifo_out <= a_data_in;
      if (b_store_in && b_mbx_in) a_mbx_out <= b_data_in;
      if (b_store_in && !b_mbx_in) a_fifo_out <= b_data_in;
    end
  end
endmodule // dppu_store_model

// [sim/tb_top.sv]
// Self-checking bench for the dual-port byte parity unit.
// Assumes one reference clock; the store model stands in for FIFO and mailbox storage.
`timescale 1ns/100ps
module tb_top;
  import dppu_pkg::*;
  logic ref_clk_in = 1'b0, srst_in = 1'b1, parity_odd_select_in = 1'b0;
  logic porta_parity_gen_select_in = 1'b0, portb_parity_gen_select_in = 1'b0;
  logic porta_wr_in = 1'b0, porta_rd_in = 1'b0, porta_mbx_select_in = 1'b0;
  logic portb_wr_in = 1'b0, portb_rd_in = 1'b0, portb_size_select_lo_in = 1'b0, portb_size_select_hi_in = 1'b0;
  logic [35:0] porta_data_in = '0, portb_data_in = '0, porta_fifo_word_in, porta_mbx_word_in;
  logic [35:0] portb_fifo_word_in, portb_mbx_word_in, porta_rd_data_out, portb_rd_data_out;
  logic [35:0] porta_store_data_out, portb_store_data_out;
  logic [3:0] reg_addr_in = '0;
  logic [31:0] reg_wdata_in = '0, reg_rdata_out;
  logic reg_wr_in = 1'b0, reg_rd_in = 1'b0, porta_parity_error_flag_n_out, portb_parity_error_flag_n_out;
  logic porta_store_out, portb_store_out, porta_store_mbx_out, portb_store_mbx_out;
  logic [1:0] portb_size_out;
  int miscompares = 0;
  int comparisons = 0;

  dppu_parity_unit i_dppu_parity_unit (.ref_clk_in, .srst_in, .parity_odd_select_in,
    .porta_parity_gen_select_in, .portb_parity_gen_select_in, .porta_wr_in, .porta_rd_in,
    .porta_mbx_select_in, .porta_data_in, .porta_fifo_word_in, .porta_mbx_word_in, .portb_wr_in,
    .portb_rd_in, .portb_size_select_lo_in, .portb_size_select_hi_in, .portb_data_in,
    .portb_fifo_word_in, .portb_mbx_word_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in,
    .reg_rdata_out, .porta_parity_error_flag_n_out, .portb_parity_error_flag_n_out,
    .porta_rd_data_out, .portb_rd_data_out, .porta_store_out, .portb_store_out,
    .porta_store_mbx_out, .portb_store_mbx_out, .porta_store_data_out, .portb_store_data_out,
    .portb_size_out);
  dppu_store_model i_dppu_store_model (.clk_in(ref_clk_in), .srst_in(srst_in),
    .a_store_in(porta_store_out), .a_mbx_in(porta_store_mbx_out), .a_data_in(porta_store_data_out),
    .b_store_in(portb_store_out), .b_mbx_in(portb_store_mbx_out), .b_data_in(portb_store_data_out),
    .a_fifo_out(porta_fifo_word_in), .a_mbx_out(porta_mbx_word_in),
    .b_fifo_out(portb_fifo_word_in), .b_mbx_out(portb_mbx_word_in));

  initial
  begin
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  // Builds a word from four data bytes with chosen parity; a set bit in bad spoils that lane.
  function automatic logic [35:0] mk(input logic [31:0] d, input logic o, input logic [3:0] bad);
    logic [35:0] w;
    for (int i = 0; i < 4; i++)
    begin
      w[i*9 +: 8] = d[i*8 +: 8];
      w[i*9+8] = ^d[i*8 +: 8] ^ o ^ bad[i];
    end
    return w;
  endfunction

  function automatic logic [35:0] gen(input logic [35:0] w, input logic o);
    return mk({w[34:27], w[25:18], w[16:9], w[7:0]}, o, 4'h0);
  endfunction

  task automatic chk(input logic [35:0] got, input logic [35:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic ticks(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  task automatic rw(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask

  task automatic rr(input logic [3:0] a, input logic [31:0] e, input string what);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1 chk({4'h0, reg_rdata_out}, {4'h0, e}, what);
  endtask

  // One port cycle: w selects write, m the port A mailbox (port B ignores m); outputs are judged 1 ns after the taking edge.
  task automatic acc(input logic b, input logic w, input logic m, input logic [35:0] d);
    @(posedge ref_clk_in);
    if (b) {portb_wr_in, portb_rd_in, portb_data_in} <= {w, !w, d};
    else {porta_wr_in, porta_rd_in, porta_mbx_select_in, porta_data_in} <= {w, !w, m, d};
    @(posedge ref_clk_in);
    {porta_wr_in, porta_rd_in, portb_wr_in, portb_rd_in, porta_mbx_select_in} <= 5'h00;
    #1;
  endtask

  task automatic bsize(input logic [1:0] c);
    @(posedge ref_clk_in);
    {portb_size_select_hi_in, portb_size_select_lo_in} <= c;
    ticks(2);
  endtask

  task automatic t_reset;
    chk(porta_parity_error_flag_n_out, 1, "flag A reset");
    chk(portb_parity_error_flag_n_out, 1, "flag B reset");
    rr(DPPU_REG_CTRL, 32'h3, "ctrl reset");
    rr(DPPU_REG_STATUS, 32'h0, "status reset");
    rr(DPPU_REG_FLAGS, 32'h3, "flags reset");
    rw(4'hC, 32'hFFFF_FFFF);
    rr(4'hC, 32'h0, "unmapped");
    $display("test reset done");
  endtask

  task automatic t_lanes;
    logic [3:0] bad;
    logic [35:0] w;
    for (int o = 0; o < 2; o++)
    begin
      parity_odd_select_in <= o[0];
      ticks(3);
      for (int i = 0; i < 5; i++)
      begin
        bad = (i < 4) ? 4'(1 << i) : 4'h0;
        w = mk(32'h5A3C_96E1 ^ 32'(i), o[0], bad);
        acc(1'b0, 1'b1, 1'b0, w);
        chk(porta_parity_error_flag_n_out, bad == 4'h0, "lane flag A");
        chk(porta_store_data_out, w, "store A");
        chk(porta_store_out, 1, "store pulse A");
      end
      rr(DPPU_REG_STATUS, 32'h0F, "sticky lanes A");
      rw(DPPU_REG_STATUS, 32'h0F);
      rr(DPPU_REG_STATUS, 32'h00, "status cleared");
    end
    rr(DPPU_REG_FLAGS, 32'h7, "flags odd");
    $display("test lanes done");
  endtask

  task automatic t_sizes;
    logic [1:0] codes [3] = '{DPPU_SIZE_LONG, DPPU_SIZE_WORD, DPPU_SIZE_BYTE};
    logic [3:0] masks [3] = '{DPPU_LANES_LONG, DPPU_LANES_WORD, DPPU_LANES_BYTE};
    for (int c = 0; c < 3; c++)
    begin
      bsize(codes[c]);
      for (int l = 0; l < 4; l++)
      begin
        acc(1'b1, 1'b1, 1'b0, mk(32'hC3A5_0F71, 1'b1, 4'(1 << l)));
        chk(portb_parity_error_flag_n_out, !masks[c][l], "sized flag B");
        chk(portb_size_out, codes[c], "size in force");
      end
    end
    rr(DPPU_REG_STATUS, 32'hF0, "sticky lanes B");
    bsize(DPPU_SIZE_MBOX);
    acc(1'b1, 1'b1, 1'b0, mk(32'h1234_5678, 1'b1, 4'h8));
    chk(portb_parity_error_flag_n_out, 0, "mailbox all lanes");
    chk(portb_store_mbx_out, 1, "mailbox store B");
    chk(portb_size_out, DPPU_SIZE_BYTE, "size kept");
    bsize(DPPU_SIZE_LONG);
    $display("test sizes done");
  endtask

  task automatic t_gen;
    logic [35:0] fw = mk(32'h8E17_2B64, 1'b1, 4'h5);
    logic [35:0] mw = mk(32'h39D0_E4A2, 1'b1, 4'hA);
    // Port B's mailbox write in the size test left this word for port A.
    logic [35:0] aw = mk(32'h1234_5678, 1'b1, 4'h8);
    acc(1'b0, 1'b1, 1'b0, fw);
    acc(1'b0, 1'b1, 1'b1, mw);
    chk(porta_store_mbx_out, 1, "mailbox store A");
    acc(1'b1, 1'b1, 1'b0, mw);
    chk({portb_store_out, portb_store_mbx_out}, 2'h2, "store pulse B");
    chk(portb_store_data_out, mw, "store B");
    ticks(1);
    acc(1'b1, 1'b0, 1'b0, 36'h0);
    chk(portb_rd_data_out, fw, "stored parity out");
    portb_parity_gen_select_in <= 1'b1;
    porta_parity_gen_select_in <= 1'b1;
    for (int o = 1; o >= 0; o--)
    begin
      parity_odd_select_in <= o[0];
      ticks(3);
      acc(1'b1, 1'b0, 1'b0, 36'h0);
      chk(portb_rd_data_out, gen(fw, o[0]), "generated B");
      acc(1'b0, 1'b0, 1'b0, 36'h0);
      chk(porta_rd_data_out, gen(mw, o[0]), "generated A");
    end
    parity_odd_select_in <= 1'b1;
    bsize(DPPU_SIZE_MBOX);
    acc(1'b1, 1'b0, 1'b0, 36'h0);
    chk(portb_parity_error_flag_n_out, 1, "mbx flag B high");
    chk(portb_rd_data_out, gen(mw, 1'b1), "mbx gen B");
    chk(portb_mbx_word_in, mw, "mailbox kept B");
    bsize(DPPU_SIZE_LONG);
    acc(1'b0, 1'b0, 1'b1, 36'h0);
    chk(porta_parity_error_flag_n_out, 1, "mbx flag A high");
    chk(porta_rd_data_out, gen(aw, 1'b1), "mbx gen A");
    chk(porta_mbx_word_in, aw, "mailbox kept A");
    $display("test generate done");
  endtask

  task automatic t_ctrl;
    logic [35:0] w = mk(32'h0BAD_F00D, 1'b1, 4'h2);
    rw(DPPU_REG_CTRL, 32'h0);
    acc(1'b0, 1'b1, 1'b0, w);
    chk(porta_parity_error_flag_n_out, 1, "check off");
    chk(porta_store_data_out, w, "data passes");
    rw(DPPU_REG_CTRL, 32'h3);
    $display("test control done");
  endtask

  task automatic complete_run;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    ticks(4);
    srst_in <= 1'b0;
    ticks(3);
    t_reset();
    t_lanes();
    t_sizes();
    t_gen();
    t_ctrl();
    complete_run();
  end

  // The scenarios need well under a thousand cycles; five thousand means a hang.
  initial
  begin
    ticks(5000);
    miscompares++;
    complete_run();
  end
endmodule // tb_top
